// File: cio_pkg.sv
// Constants of the cyclic IO exchange block: register map, IO RAM
// windows, event bit positions and reset values.
// Assumes a 32-bit AXI4-Lite register bus with 16-bit byte addresses.
package cio_pkg;

  // ------------------
  // Bus geometry
  // ------------------
  localparam int ADDR_W = 16; // Byte address width
  localparam int DATA_W = 32; // Data width
  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

  // ------------------
  // Register offsets (byte addresses)
  // ------------------
  localparam logic [15:0] OFS_ACK = 16'h0020; // event_acknowledge_low
  localparam logic [15:0] OFS_EVENT = 16'h003C; // network_event_flags_low
  localparam logic [15:0] OFS_MASK = 16'h0040; // Interrupt mask
  localparam logic [15:0] OFS_CTRL = 16'h0044; // Swap and submit strobes
  localparam logic [15:0] OFS_PLEN = 16'h0048; // init_param_length
  localparam logic [15:0] OFS_STAT = 16'h004C; // Block status
  localparam logic [15:0] OFS_PTR = 16'h0100; // Pointer table
  localparam logic [15:0] IORAM_BASE = 16'h2000; // Pointers count from here
  localparam logic [15:0] RX_WIN = 16'h0000; // Output data window
  localparam logic [15:0] TX_WIN = 16'h0010; // Input data window
  localparam logic [15:0] PRM_WIN = 16'h0020; // Parameter space

  // ------------------
  // Field positions
  // ------------------
  localparam int EV_AR1_BIT = 7; // New data on AR1
  localparam int EV_AR0_BIT = 8; // New data on AR0
  localparam logic [31:0] EV_USED = 32'h0000_0180; // Implemented event bits
  localparam int CTRL_SWAP_BIT = 0; // swap_output_buffer
  localparam int CTRL_SUBMIT_BIT = 1; // submit_input_buffer
  localparam int STAT_DIFF_BIT = 0; // Module difference pending
  localparam int STAT_RXFRESH_BIT = 1; // Unclaimed receive data
  localparam int STAT_TXFRESH_BIT = 2; // Submitted input not yet sent
  localparam int STAT_RXIDX_LSB = 4; // Host receive buffer index
  localparam int STAT_TXIDX_LSB = 8; // Host send buffer index

  // ------------------
  // Sizes and reset values
  // ------------------
  localparam int NBYTES = 16; // Bytes per IO buffer
  localparam int NBUF = 3; // Triple buffering
  localparam logic [15:0] PRM_HDR_LEN = 16'h0006; // Record header bytes
  localparam logic [31:0] EVENT_RST = 32'h0000_0000; // Events clear
  localparam logic [31:0] MASK_RST = 32'h0000_0000; // All masked
  localparam logic [15:0] PLEN_RST = PRM_HDR_LEN; // Header only reserved
  localparam logic [1:0] TB_PROD_RST = 2'h0; // Triple buffer start slots
  localparam logic [1:0] TB_CONS_RST = 2'h1;
  localparam logic [1:0] TB_SPARE_RST = 2'h2;

  // ------------------
  // Address decode regions
  // ------------------
  typedef enum logic [10:0] {
    REG_NONE = 11'h001,
    REG_ACK = 11'h002,
    REG_EVT = 11'h004,
    REG_MASK = 11'h008,
    REG_CTRL = 11'h010,
    REG_PLEN = 11'h020,
    REG_STAT = 11'h040,
    REG_PTR = 11'h080,
    RAM_RX = 11'h100,
    RAM_TX = 11'h200,
    RAM_PRM = 11'h400
  } cio_region_t;

endpackage

// File: cio_triple_buf.sv
// Three-slot buffer index manager: one producer, one consumer, one spare.
// Assumes publish and take are single-cycle pulses in the clk domain.
module cio_triple_buf (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic publish, // Producer finished its slot
  input wire logic take, // Consumer asks for latest slot
  output logic [1:0] prodIdx, // Slot the producer fills
  output logic [1:0] consIdx, // Slot the consumer owns
  output logic fresh // Spare holds unclaimed data
);
  import cio_pkg::*;

  // ------------------
  // State
  // ------------------
  typedef struct packed {
    logic [1:0] prod; // Producer slot
    logic [1:0] cons; // Consumer slot
    logic [1:0] spare; // Free slot
    logic fresh; // Spare is newer than consumer slot
  } cio_tb_state_t;

  cio_tb_state_t q; // Registered state
  cio_tb_state_t d; // Next state

  // Publish first, then take, so a same-cycle pair hands over the new data
  always_comb begin
    d = q;
    if (publish) begin
      d.prod = q.spare;
      d.spare = q.prod;
      d.fresh = 1'b1;
    end
    if (take && d.fresh) begin
      d.cons = d.spare;
      d.spare = q.cons;
      d.fresh = 1'b0;
    end
    // No fresh slot: the consumer keeps its old slot, contents may repeat
  end

  // Register the state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{prod: TB_PROD_RST, cons: TB_CONS_RST, spare: TB_SPARE_RST, fresh: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign prodIdx = q.prod;
  assign consIdx = q.cons;
  assign fresh = q.fresh;

endmodule // cio_triple_buf

// File: cio_exchange.sv
// Cyclic IO exchange: triple-buffered receive and send IO RAM, new-data
// events, parameter placement and module difference flag, AXI4-Lite slave.
// Assumes the network side drives one-cycle strobes synchronous to clk.
// Function
// - Three buffers each for receive and send
// - Swap hands host latest completed receive buffer
// - Swap itself never signals new data
// - Bits 7/8 at 0x3C flag AR1/AR0 data
// - Ack write one at 0x20 clears bit
// - Pointers count from IO RAM base 0x2000
// - Frame bytes placed in controller-given order
// - Parameters written into host-reserved space
// - Missing module attaches difference block
//
// Chosen here: the AXI4-Lite register port.
module cio_exchange #(
  parameter logic [15:0] HELD_MODULE_ID = 16'h0001 // Arbitrary value
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic [cio_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [cio_pkg::DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [cio_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [cio_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic irq, // Level interrupt
  input wire logic netCfgValid, // Order table entry strobe
  input wire logic [3:0] netCfgIndex, // Buffer byte slot
  input wire logic [3:0] netCfgOffset, // Frame offset feeding that slot
  input wire logic netRxValid, // Received frame byte strobe
  input wire logic [7:0] netRxData, // Received frame byte
  input wire logic netRxLast, // Last byte of frame
  input wire logic netRxAr, // Frame relation: 1 = AR1, 0 = AR0
  input wire logic netTxNext, // Network claims latest input buffer
  input wire logic [3:0] netTxIndex, // Send byte select
  output logic [7:0] netTxData, // Send byte, one cycle after select
  input wire logic netParamStart, // Start of parameter record
  input wire logic netParamValid, // Parameter byte strobe
  input wire logic [7:0] netParamData, // Parameter byte
  input wire logic netConnValid, // Expected module strobe
  input wire logic [15:0] netConnModuleId, // Expected module identity
  output logic modDiffAttach // Attach difference block to response
);
  import cio_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awHeld; // Write address captured
    logic [15:0] awAddr; // Captured write address
    logic wHeld; // Write data captured
    logic [31:0] wData; // Captured write data
    logic [3:0] wStrb; // Captured byte enables
    logic bValid; // Write response pending
    logic [1:0] bResp; // Write response code
    logic rValid; // Read data pending
    logic [31:0] rData; // Read data
    logic [1:0] rResp; // Read response code
    logic [31:0] evt; // Sticky event flags
    logic [31:0] mask; // Interrupt mask
    logic [15:0] plen; // Reserved parameter length
    logic modDiff; // Module difference seen
    logic [NBYTES-1:0][3:0] order; // Frame offset per buffer slot
    logic [3:0] rxCnt; // Byte position in current frame
    logic rxOver; // Frame longer than buffer
    logic [NBUF-1:0][NBYTES-1:0][7:0] rxBuf; // Receive buffers
    logic [NBUF-1:0][NBYTES-1:0][7:0] txBuf; // Send buffers
    logic [NBYTES-1:0][7:0] prm; // Parameter space
    logic [4:0] prmCnt; // Parameter write position
    logic [7:0] txData; // Send byte register
  } cio_state_t;

  cio_state_t q; // Registered state
  cio_state_t d; // Next state
  logic wrFire; // Write executes this cycle
  cio_region_t wrReg; // Write target region
  cio_region_t rdReg; // Read target region
  logic swapReq; // Host swap strobe
  logic submitReq; // Host submit strobe
  logic rxPublish; // Frame complete
  logic [1:0] rxProd; // Slot network fills
  logic [1:0] rxCons; // Slot host reads
  logic rxFresh; // Unclaimed receive data
  logic [1:0] txProd; // Slot host fills
  logic [1:0] txCons; // Slot network sends
  logic txFresh; // Unclaimed send data

  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  // ----------------------------------------------------------------
  function automatic cio_region_t regionOf(input logic [15:0] a);
    logic [15:0] w;
    w = {a[15:2], 2'h0};
    if (w == OFS_ACK) regionOf = REG_ACK;
    else if (w == OFS_EVENT) regionOf = REG_EVT;
    else if (w == OFS_MASK) regionOf = REG_MASK;
    else if (w == OFS_CTRL) regionOf = REG_CTRL;
    else if (w == OFS_PLEN) regionOf = REG_PLEN;
    else if (w == OFS_STAT) regionOf = REG_STAT;
    else if (w[15:6] == OFS_PTR[15:6]) regionOf = REG_PTR;
    else if (w[15:4] == 12'(16'(IORAM_BASE + RX_WIN) >> 4)) regionOf = RAM_RX;
    else if (w[15:4] == 12'(16'(IORAM_BASE + TX_WIN) >> 4)) regionOf = RAM_TX;
    else if (w[15:4] == 12'(16'(IORAM_BASE + PRM_WIN) >> 4)) regionOf = RAM_PRM;
    else regionOf = REG_NONE;
  endfunction

  // Pick one little-endian word out of a 16-byte buffer
  function automatic logic [31:0] wordOf(input logic [NBYTES-1:0][7:0] b,
                                         input logic [1:0] w);
    wordOf = {b[{w, 2'h3}], b[{w, 2'h2}], b[{w, 2'h1}], b[{w, 2'h0}]};
  endfunction

  // ----------------------------------------------------------------
  // Buffer index managers
  // ----------------------------------------------------------------
  // Receive: network produces, host consumes on swap
  cio_triple_buf rxTb (
    .clk(clk),
    .sys_rst(sys_rst),
    .publish(rxPublish),
    .take(swapReq),
    .prodIdx(rxProd),
    .consIdx(rxCons),
    .fresh(rxFresh)
  );

  // Send: host produces on submit, network consumes
  cio_triple_buf txTb (
    .clk(clk),
    .sys_rst(sys_rst),
    .publish(submitReq),
    .take(netTxNext),
    .prodIdx(txProd),
    .consIdx(txCons),
    .fresh(txFresh)
  );

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  assign wrFire = q.awHeld && q.wHeld && !q.bValid;
  assign wrReg = regionOf(q.awAddr);
  assign rdReg = regionOf(s_axi_araddr);
  // Strobes fire only with byte lane 0 enabled
  assign swapReq = wrFire && (wrReg == REG_CTRL) && q.wStrb[0]
                   && q.wData[CTRL_SWAP_BIT];
  assign submitReq = wrFire && (wrReg == REG_CTRL) && q.wStrb[0]
                     && q.wData[CTRL_SUBMIT_BIT];
  assign rxPublish = netRxValid && netRxLast;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Bus channel capture, address and data in either order
    if (s_axi_awvalid && !q.awHeld) begin
      d.awHeld = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wHeld) begin
      d.wHeld = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end

    // Register writes; swap and submit need byte lane 0, ack and event clears ignore byte enables
    if (wrFire) begin
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bValid = 1'b1;
      d.bResp = (wrReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (wrReg)
        REG_ACK, REG_EVT: begin // Write one clears, zero leaves alone
          d.evt = q.evt & ~(q.wData & EV_USED);
        end
        REG_MASK: begin
          for (int k = 0; k < 4; k++) begin
            if (q.wStrb[k]) d.mask[8*k +: 8] = q.wData[8*k +: 8];
          end
        end
        REG_PLEN: begin // Host reserves header plus parameter bytes
          if (q.wStrb[0]) d.plen[7:0] = q.wData[7:0];
          if (q.wStrb[1]) d.plen[15:8] = q.wData[15:8];
        end
        RAM_TX: begin // Host fills its own send slot only
          for (int k = 0; k < 4; k++) begin
            if (q.wStrb[k]) d.txBuf[txProd][{q.awAddr[3:2], 2'(k)}] = q.wData[8*k +: 8];
          end
        end
        default: begin
          // Read-only, strobe or unmapped: nothing stored
        end
      endcase
    end

    // Register reads, answered one cycle after the address is taken
    if (s_axi_arvalid && !q.rValid) begin
      d.rValid = 1'b1;
      d.rResp = RESP_OKAY;
      d.rData = 32'h0000_0000;
      unique case (rdReg)
        REG_EVT: d.rData = q.evt;
        REG_MASK: d.rData = q.mask;
        REG_PLEN: d.rData = {16'h0000, q.plen};
        REG_STAT: begin
          d.rData[STAT_DIFF_BIT] = q.modDiff;
          d.rData[STAT_RXFRESH_BIT] = rxFresh;
          d.rData[STAT_TXFRESH_BIT] = txFresh;
          d.rData[STAT_RXIDX_LSB +: 2] = rxCons;
          d.rData[STAT_TXIDX_LSB +: 2] = txProd;
        end
        REG_PTR: begin // Slot offset counted from the IO RAM base
          d.rData = {16'h0000, 16'(RX_WIN + {12'h000, s_axi_araddr[5:2]})};
        end
        RAM_RX: d.rData = wordOf(q.rxBuf[rxCons], s_axi_araddr[3:2]);
        RAM_TX: d.rData = wordOf(q.txBuf[txProd], s_axi_araddr[3:2]);
        RAM_PRM: d.rData = wordOf(q.prm, s_axi_araddr[3:2]);
        REG_ACK, REG_CTRL: d.rData = 32'h0000_0000; // Write-only
        REG_NONE: d.rResp = RESP_SLVERR;
        default: d.rResp = RESP_SLVERR;
      endcase
    end

    // Controller-given placement order for received bytes
    if (netCfgValid) begin
      d.order[netCfgIndex] = netCfgOffset;
    end

    // Frame bytes land in every slot mapped to this frame offset
    if (netRxValid) begin
      if (!q.rxOver) begin
        for (int i = 0; i < NBYTES; i++) begin
          if (q.order[i] == q.rxCnt) d.rxBuf[rxProd][i] = netRxData;
        end
      end
      if (netRxLast) begin
        d.rxCnt = 4'h0;
        d.rxOver = 1'b0;
      end else begin
        d.rxCnt = 4'(q.rxCnt + 4'h1);
        if (q.rxCnt == 4'(NBYTES - 1)) d.rxOver = 1'b1;
      end
    end

    // New-data events set after the clear so arrival wins
    if (rxPublish) begin
      if (netRxAr) d.evt[EV_AR1_BIT] = 1'b1;
      else d.evt[EV_AR0_BIT] = 1'b1;
    end

    // Parameter record written into reserved space, never beyond it
    if (netParamStart) begin
      d.prmCnt = 5'h00;
    end else if (netParamValid && ({11'h000, q.prmCnt} < q.plen)
                 && (q.prmCnt < 5'(NBYTES))) begin
      d.prm[q.prmCnt[3:0]] = netParamData;
      d.prmCnt = 5'(q.prmCnt + 5'h01);
    end

    // Expected module compared against the held one
    if (netConnValid) begin
      d.modDiff = (netConnModuleId != HELD_MODULE_ID);
    end

    // Send byte always from the slot the network owns
    d.txData = q.txBuf[txCons][netTxIndex];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Order table resets to zero: until configured, every slot mirrors byte 0
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.evt <= EVENT_RST;
      q.mask <= MASK_RST;
      q.plen <= PLEN_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !q.awHeld;
  assign s_axi_wready = !q.wHeld;
  assign s_axi_bvalid = q.bValid;
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = !q.rValid;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rdata = q.rData;
  assign s_axi_rresp = q.rResp;
  assign irq = |(q.evt & q.mask); // Level while any unmasked event stands
  assign netTxData = q.txData;
  assign modDiffAttach = q.modDiff;

endmodule // cio_exchange

// File: cio_exchange_assertions.sv
// Checker for cio_exchange: bus answers, event interrupt, module difference.
// Assumes it is bound to cio_exchange, sees only its ports, one clock domain.
module cio_exchange_assertions #(
  parameter logic [15:0] HELD_MODULE_ID = 16'h0001 // Arbitrary value
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [cio_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic irq, // Level interrupt
  input wire logic netRxValid, // Frame byte strobe
  input wire logic netRxLast, // Last frame byte
  input wire logic netConnValid, // Expected module strobe
  input wire logic [15:0] netConnModuleId, // Expected module identity
  input wire logic modDiffAttach // Difference block flag
);
  import cio_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ------------------
  // Bus answers: a write pair taken while idle answers two edges on
  // ------------------
  property p_w_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##2 s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans)
    else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  // ------------------
  // Events: only a frame end or a register write moves the interrupt
  // ------------------
  property p_irq_rise;
    $rose(irq) |-> $past(netRxValid && netRxLast) || $rose(s_axi_bvalid);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without new data");
  property p_irq_fall;
    $fell(irq) |-> $rose(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a write");
  // ------------------
  // Module difference follows the last connect only
  // ------------------
  property p_diff;
    netConnValid |=> modDiffAttach == ($past(netConnModuleId) != HELD_MODULE_ID);
  endproperty
  a_diff: assert property (p_diff)
    else $error("difference flag wrong");
  property p_diff_hold;
    !netConnValid |=> $stable(modDiffAttach);
  endproperty
  a_diff_hold: assert property (p_diff_hold)
    else $error("difference flag moved");
endmodule // cio_exchange_assertions

bind cio_exchange cio_exchange_assertions #(.HELD_MODULE_ID(HELD_MODULE_ID))
  cio_exchange_assertions_inst (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq,
  .netRxValid, .netRxLast, .netConnValid, .netConnModuleId, .modDiffAttach);

// File: cio_net_model.sv
// Network side model: order table, frames, parameters, connects, send bytes.
// Assumes callers enter each task just after a rising edge of clk.
module cio_net_model (
  input wire logic clk, // System clock
  output logic netCfgValid, // Order entry strobe
  output logic [3:0] netCfgIndex, // Buffer slot
  output logic [3:0] netCfgOffset, // Frame position
  output logic netRxValid, // Frame byte strobe
  output logic [7:0] netRxData, // Frame byte
  output logic netRxLast, // Last byte
  output logic netRxAr, // Relation
  output logic netTxNext, // Claim send buffer
  output logic [3:0] netTxIndex, // Send byte select
  input wire logic [7:0] netTxData, // Send byte
  output logic netParamStart, // Record start
  output logic netParamValid, // Record byte strobe
  output logic [7:0] netParamData, // Record byte
  output logic netConnValid, // Connect strobe
  output logic [15:0] netConnModuleId // Expected module
);
  initial begin
    {netCfgValid, netRxValid, netRxLast, netRxAr, netTxNext, netParamStart} = '0;
    {netCfgIndex, netCfgOffset, netRxData, netTxIndex} = '0;
    {netParamValid, netParamData, netConnValid, netConnModuleId} = '0;
  end
  // Reverse order: slot i takes frame byte 15-i
  task automatic cfgRev();
    for (int i = 0; i < 16; i++) begin
      netCfgValid <= 1'b1;
      netCfgIndex <= 4'(i);
      netCfgOffset <= 4'(15 - i);
      @(posedge clk);
    end
    netCfgValid <= 1'b0;
  endtask
  // Sixteen bytes first+k; idle data line shows the inverse, not a hold
  task automatic frame(input logic [7:0] first, input logic ar);
    @(posedge clk);
    for (int k = 0; k < 16; k++) begin
      netRxValid <= 1'b1;
      netRxData <= first + 8'(k);
      netRxLast <= (k == 15);
      netRxAr <= ar;
      @(posedge clk);
    end
    netRxValid <= 1'b0;
    netRxLast <= 1'b0;
    netRxData <= ~netRxData;
  endtask
  task automatic param(input int n);
    @(posedge clk);
    netParamStart <= 1'b1;
    @(posedge clk);
    netParamStart <= 1'b0;
    for (int k = 0; k < n; k++) begin
      netParamValid <= 1'b1;
      netParamData <= 8'hA0 + 8'(k);
      @(posedge clk);
    end
    netParamValid <= 1'b0;
  endtask
  // Extra edge so the flag is settled on return
  task automatic conn(input logic [15:0] id);
    @(posedge clk);
    netConnValid <= 1'b1;
    netConnModuleId <= id;
    @(posedge clk);
    netConnValid <= 1'b0;
    netConnModuleId <= ~id;
    @(posedge clk);
  endtask
  task automatic claim();
    @(posedge clk);
    netTxNext <= 1'b1;
    @(posedge clk);
    netTxNext <= 1'b0;
  endtask
  // Byte appears one edge after the select
  task automatic txbyte(input logic [3:0] i, output logic [7:0] b);
    @(posedge clk);
    netTxIndex <= i;
    @(posedge clk);
    @(posedge clk);
    b = netTxData;
  endtask
endmodule // cio_net_model

// File: testbench.sv
// Self-checking bench for cio_exchange over AXI4-Lite with a network model.
// Assumes cio_pkg is compiled first; bready and rready stay high throughout.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cio_pkg::*;
  logic clk, sys_rst, irq, modDiffAttach;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, netCfgIndex, netCfgOffset, netTxIndex;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, netCfgValid, netRxValid;
  logic netRxLast, netRxAr, netTxNext, netParamStart, netParamValid, netConnValid;
  logic [7:0] netRxData, netTxData, netParamData, b;
  logic [15:0] netConnModuleId;
  int failures, checksDone;
  cio_exchange cio_exchange_inst (.*);
  cio_net_model net_inst (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------------------
  // Compare, bus tasks and closing report
  // ------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Word of four bytes first, first+step, ... with byte 0 lowest
  function automatic logic [31:0] wordOf(input logic [7:0] first, input int step);
    for (int j = 0; j < 4; j++) wordOf[8*j +: 8] = first + 8'(j * step);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk(32'(s_axi_bresp), 32'(er));
        return;
      end
    end
    failures++;
    wrap_up();
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
        return;
      end
    end
    failures++;
    wrap_up();
  endtask
  task automatic wrap_up();
    if (failures == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ------------------
  // Main sequence
  // ------------------
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready, sys_rst} = 7'h7F;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_EVENT, EVENT_RST);
    rd(OFS_PLEN, 32'(PLEN_RST));
    rd(16'h0050, 32'h0, RESP_SLVERR);
    wr(16'h0050, 32'hFFFF_FFFF, RESP_SLVERR);
    for (int i = 0; i < 16; i++) rd(OFS_PTR + 16'(4 * i), 32'(i));
    net_inst.cfgRev();
    net_inst.frame(8'h10, 1'b0);
    net_inst.frame(8'h30, 1'b0);
    rd(OFS_STAT, 32'h12);
    rd(OFS_EVENT, 32'h100);
    chk(32'(irq), 32'h0);
    wr(OFS_MASK, 32'h180);
    rd(OFS_MASK, 32'h180);
    chk(32'(irq), 32'h1);
    repeat (3) wr(OFS_CTRL, 32'h1);
    for (int w = 0; w < 4; w++)
      rd(IORAM_BASE + RX_WIN + 16'(4 * w), wordOf(8'h3F - 8'(4 * w), -1));
    rd(OFS_STAT, 32'h20);
    rd(OFS_EVENT, 32'h100);
    wr(OFS_ACK, 32'h80);
    rd(OFS_EVENT, 32'h100);
    wr(OFS_ACK, 32'h100);
    rd(OFS_EVENT, 32'h0);
    net_inst.frame(8'h50, 1'b1);
    rd(OFS_EVENT, 32'h80);
    wr(OFS_ACK, 32'h80);
    chk(32'(irq), 32'h0);
    for (int w = 0; w < 4; w++)
      wr(IORAM_BASE + TX_WIN + 16'(4 * w), wordOf(8'h80 + 8'(4 * w), 1));
    wr(OFS_CTRL, 32'h2);
    net_inst.claim();
    for (int i = 0; i < 16; i++) begin
      net_inst.txbyte(4'(i), b);
      chk(32'(b), 32'h80 + 32'(i));
    end
    wr(OFS_PLEN, 32'h8);
    net_inst.param(10);
    rd(IORAM_BASE + PRM_WIN, wordOf(8'hA0, 1));
    rd(IORAM_BASE + PRM_WIN + 16'h4, wordOf(8'hA4, 1));
    rd(IORAM_BASE + PRM_WIN + 16'h8, 32'h0);
    net_inst.conn(16'h0001);
    chk(32'(modDiffAttach), 32'h0);
    net_inst.conn(16'h0005);
    chk(32'(modDiffAttach), 32'h1);
    wrap_up();
  end
endmodule // testbench
